// ===== rtl/sadc_cycle.v
/*
 * Single-address DMA bus-cycle sequencer: takes cycle descriptors from a
 * small FIFO and runs memory read or write cycles, handshaking with the
 * device by ACK-only or ACK-with-ready. Data never passes through here.
 * Assumes each mclk edge is one numbered state (mclk = twice the bus
 * clock), config inputs stable and from the mclk domain, bus pins async.
 */
// Functional notes
// - supports ack-only and ack-with-ready protocols
// - drives address and strobes, never data
// - read S0: code, address, upper strobe, R/W high
// - buffer enable held high whole cycle
// - 8-bit bus uses upper strobe as A0
// - read S2: address strobe, strobes, ack, done
// - read even byte 8-to-16 asserts lane swap
// - read S3 samples ack; errors add two waits
// - ready protocol read waits for memory and device
// - transfer-complete only on normal termination
// - read S7 negates address and data strobes
// - after cycle: next address or tri-state; negate
// - write S2: address strobe on, R/W low
// - write ready first sampled end of S1
// - write S3 tri-states, asserts ACK and DONE
// - write even byte 8-to-16 asserts lane swap
// - ready write inserts delay and wait pairs
// - early write ack skips S6, S7; error waits
// - exception code decoded, all-high means none
// - exception code accepted after two equal samples
// - write S5 asserts data strobes
`timescale 1ns/100ps
`include "sadc_regs.vh"
module sadc_cycle
#(
   parameter FIFO_DEPTH = `SADC_FIFO_DEPTH
)
(
   // clock and reset
   input  wire        mclk,
   input  wire        rstn,
   // descriptor stream in
   input  wire        descValid,
   output wire        descReady,
   input  wire [23:0] descAddr,
   input  wire [2:0]  descFuncCode,
   input  wire        descWrite,
   input  wire        descWord,
   input  wire        descLast,
   // static configuration
   input  wire        readyProtocol,
   input  wire        bus8,
   input  wire        device8,
   // bus address and function code
   output reg  [23:1] addrOut,
   output reg         addrMuxOe,
   output reg         addrLowOe,
   output reg  [2:0]  function_code,
   // bus control
   output reg         upperAddressStrobeN,
   output reg         addressValidStrobeN,
   output reg         upperStrobeOrA0,
   output reg         lowerStrobeOrDsN,
   output reg         readWriteN,
   output reg         dataBufferEnableN,
   output reg         cycleBusy,
   // memory termination pins
   input  wire        memoryTransferAckN,
   input  wire [2:0]  busExceptionCode,
   // device handshake
   input  wire        peripheralControlLineN,
   output reg         deviceAckN,
   output reg         doneN,
   output reg         transferCompleteStrobeN,
   output reg         byteLaneSwapN
);
   localparam [3:0] ST_IDLE = 4'h0;
   localparam [3:0] ST_S0   = 4'h1;
   localparam [3:0] ST_S1   = 4'h2;
   localparam [3:0] ST_S2   = 4'h3;
   localparam [3:0] ST_S3   = 4'h4;
   localparam [3:0] ST_RW   = 4'h5;
   localparam [3:0] ST_DWT  = 4'h6;
   localparam [3:0] ST_DLA  = 4'h7;
   localparam [3:0] ST_DLB  = 4'h8;
   localparam [3:0] ST_S4   = 4'h9;
   localparam [3:0] ST_S5   = 4'hA;
   localparam [3:0] ST_WW   = 4'hB;
   localparam [3:0] ST_S6   = 4'hC;
   localparam [3:0] ST_S7   = 4'hD;
   localparam [3:0] ST_S8   = 4'hE;
   localparam [3:0] ST_S9   = 4'hF;

   reg  [3:0]                state_reg;
   reg  [3:0]                state_next;
   reg  [`SADC_D_WIDTH-1:0]  desc_reg;
   reg  [`SADC_D_WIDTH-1:0]  desc_next;
   reg  [1:0]                cnt_reg;
   reg  [1:0]                cnt_next;
   reg                       hold_reg;
   reg                       hold_next;
   reg                       excp_reg;
   reg                       excp_next;
   reg                       earlyAck_reg;
   reg                       earlyAck_next;
   reg                       earlyRdy_reg;
   reg                       earlyRdy_next;
   reg  [2:0]                bec_reg;
   reg                       pop;

   wire [`SADC_D_WIDTH-1:0]  fifoIn;
   wire [`SADC_D_WIDTH-1:0]  fifoOut;
   wire                      fifoValid;
   wire [4:0]                syncNow;
   wire [4:0]                syncOld;

   assign fifoIn = {descLast, descWord, descWrite, descFuncCode, descAddr};

   sadc_fifo
   #(
      .WIDTH (`SADC_D_WIDTH),
      .DEPTH (FIFO_DEPTH),
      .AW    ($clog2(FIFO_DEPTH))
   )
   u_fifo
   (
      .mclk     (mclk),
      .rstn     (rstn),
      .inValid  (descValid),
      .inReady  (descReady),
      .inData   (fifoIn),
      .outValid (fifoValid),
      .outReady (pop),
      .outData  (fifoOut)
   );

   sadc_sync
   #(
      .WIDTH (`SADC_SYNC_WIDTH)
   )
   u_sync
   (
      .mclk     (mclk),
      .rstn     (rstn),
      .pinIn    ({peripheralControlLineN, memoryTransferAckN,
                  busExceptionCode}),
      .syncOut  (syncNow),
      .syncPrev (syncOld)
   );

   wire memAck  = ~syncNow[3];
   wire rdyLow  = ~syncNow[4];
   wire becErr  = (bec_reg == `SADC_BEC_BUSERR) ||
                  (bec_reg == `SADC_BEC_RETRY) ||
                  (bec_reg == `SADC_BEC_RELQ) ||
                  (bec_reg == `SADC_BEC_RESET);
   wire isWrite = desc_reg[`SADC_D_WRITE];

   always @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
         bec_reg <= `SADC_BEC_NONE;
      else if (syncNow[2:0] == syncOld[2:0])
         bec_reg <= syncNow[2:0];
   end

   always @*
   begin
      state_next    = state_reg;
      desc_next     = desc_reg;
      cnt_next      = cnt_reg;
      hold_next     = hold_reg;
      excp_next     = excp_reg;
      earlyAck_next = earlyAck_reg;
      earlyRdy_next = earlyRdy_reg;
      pop           = 1'b0;
      case (state_reg)
         ST_IDLE, ST_S7, ST_S9:
         begin
            if (state_reg == ST_S7 && isWrite)
               state_next = ST_S8;
            else if (fifoValid)
            begin
               pop           = 1'b1;
               desc_next     = fifoOut;
               state_next    = ST_S0;
               excp_next     = 1'b0;
               earlyAck_next = 1'b0;
               earlyRdy_next = 1'b0;
               hold_next     = 1'b0;
            end
            else
               state_next = ST_IDLE;
         end
         ST_S0:
            state_next = ST_S1;
         ST_S1:
         begin
            earlyRdy_next = isWrite && readyProtocol && rdyLow;
            state_next    = ST_S2;
         end
         ST_S2:
            state_next = ST_S3;
         ST_S3, ST_RW:
         begin
            if (state_reg == ST_RW && cnt_reg != 2'h0)
               cnt_next = cnt_reg - 2'h1;
            else if (state_reg == ST_RW && hold_reg)
               state_next = ST_S4;
            else if (!isWrite)
            begin
               if (becErr)
               begin
                  excp_next  = 1'b1;
                  hold_next  = 1'b1;
                  cnt_next   = `SADC_TWO_WAIT_CNT;
                  state_next = ST_RW;
               end
               else if (memAck && (!readyProtocol || rdyLow))
                  state_next = ST_S4;
               else
               begin
                  cnt_next   = `SADC_PAIR_CNT;
                  state_next = ST_RW;
               end
            end
            else
            begin
               earlyAck_next = memAck;
               excp_next     = becErr;
               if (!readyProtocol || earlyRdy_reg)
                  state_next = ST_S4;
               else if (rdyLow)
                  state_next = ST_DLA;
               else
               begin
                  cnt_next   = `SADC_PAIR_CNT;
                  state_next = ST_DWT;
               end
            end
         end
         ST_DWT:
         begin
            if (cnt_reg != 2'h0)
               cnt_next = cnt_reg - 2'h1;
            else if (rdyLow)
               state_next = ST_DLA;
            else
               cnt_next = `SADC_PAIR_CNT;
         end
         ST_DLA:
            state_next = ST_DLB;
         ST_DLB:
         begin
            earlyAck_next = earlyAck_reg || memAck;
            excp_next     = excp_reg || becErr;
            state_next    = ST_S4;
         end
         ST_S4:
            state_next = ST_S5;
         ST_S5, ST_WW:
         begin
            if (!isWrite)
               state_next = ST_S6;
            else if (state_reg == ST_WW && cnt_reg != 2'h0)
               cnt_next = cnt_reg - 2'h1;
            else if (state_reg == ST_WW && hold_reg)
               state_next = ST_S6;
            else if (excp_reg || becErr)
            begin
               excp_next  = 1'b1;
               hold_next  = 1'b1;
               cnt_next   = `SADC_PAIR_CNT;
               state_next = ST_WW;
            end
            else if (earlyAck_reg && state_reg == ST_S5)
               state_next = ST_S8;
            else if (memAck)
               state_next = ST_S6;
            else
            begin
               cnt_next   = `SADC_PAIR_CNT;
               state_next = ST_WW;
            end
         end
         ST_S6:
            state_next = ST_S7;
         ST_S8:
            state_next = ST_S9;
         default:
            state_next = ST_IDLE;
      endcase
   end

   // output decode from the next state so pins change with the state
   wire       nAct  = state_next != ST_IDLE;
   wire       nUp   = state_next == ST_S0 || state_next == ST_S1;
   wire       nW    = desc_next[`SADC_D_WRITE];
   wire       nA0   = desc_next[0];
   wire       nWord = desc_next[`SADC_D_WORD];
   wire       nPre3 = nUp || state_next == ST_S2;
   wire       nEndR = state_next == ST_S7;
   wire       nEnd  = nW ? state_next == ST_S9 : nEndR;
   wire       nStrR = nAct && !nUp && !nEndR;
   wire       nStrW = state_next == ST_S5 || state_next == ST_WW ||
                      state_next == ST_S6 || state_next == ST_S7 ||
                      state_next == ST_S8;
   wire       nStrb = nW ? nStrW : nStrR;
   wire       nAckD = nAct && !nUp && !(nW && state_next == ST_S2);
   wire       nCmpl = !excp_next &&
                      (nW ? (state_next == ST_S8 || state_next == ST_S9)
                          : (state_next == ST_S6 || state_next == ST_S7));

   always @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
      begin
         state_reg               <= ST_IDLE;
         desc_reg                <= {`SADC_D_WIDTH{1'b0}};
         cnt_reg                 <= 2'h0;
         hold_reg                <= 1'b0;
         excp_reg                <= 1'b0;
         earlyAck_reg            <= 1'b0;
         earlyRdy_reg            <= 1'b0;
         addrOut                 <= 23'h000000;
         addrMuxOe               <= 1'b0;
         addrLowOe               <= 1'b0;
         function_code           <= 3'h7;
         upperAddressStrobeN     <= 1'b1;
         addressValidStrobeN     <= 1'b1;
         upperStrobeOrA0         <= 1'b1;
         lowerStrobeOrDsN        <= 1'b1;
         readWriteN              <= 1'b1;
         dataBufferEnableN       <= 1'b1;
         cycleBusy               <= 1'b0;
         deviceAckN              <= 1'b1;
         doneN                   <= 1'b1;
         transferCompleteStrobeN <= 1'b1;
         byteLaneSwapN           <= 1'b1;
      end
      else
      begin
         state_reg    <= state_next;
         desc_reg     <= desc_next;
         cnt_reg      <= cnt_next;
         hold_reg     <= hold_next;
         excp_reg     <= excp_next;
         earlyAck_reg <= earlyAck_next;
         earlyRdy_reg <= earlyRdy_next;
         cycleBusy    <= nAct;
         addrOut       <= desc_next[`SADC_D_ADDR_MSB:1];
         function_code <= desc_next[`SADC_D_FC_MSB:`SADC_D_FC_LSB];
         // mux pins only carry address, released from S3 on
         addrMuxOe     <= nPre3 && nAct;
         addrLowOe     <= nAct;
         upperAddressStrobeN <= !nUp;
         addressValidStrobeN <= !(nAct && !nUp && !nEnd);
         readWriteN          <= !(nW && nAct && !nUp);
         dataBufferEnableN   <= 1'b1;
         if (bus8)
         begin
            upperStrobeOrA0  <= nAct ? nA0 : 1'b1;
            lowerStrobeOrDsN <= !nStrb;
         end
         else
         begin
            upperStrobeOrA0  <= !(nStrb && (nWord || !nA0));
            lowerStrobeOrDsN <= !(nStrb && (nWord || nA0));
         end
         deviceAckN <= !nAckD;
         doneN      <= !(nAckD && desc_next[`SADC_D_LAST]);
         transferCompleteStrobeN <= !nCmpl;
         byteLaneSwapN <= !(nAckD && device8 && !bus8 && !nWord && !nA0);
      end
   end
endmodule

// ===== rtl/sadc_fifo.v
/*
 * Small synchronous FIFO with valid/ready on both sides.
 * Assumes one clock; DEPTH a power of two.
 */
`timescale 1ns/100ps
module sadc_fifo
#(
   parameter WIDTH = 30,
   parameter DEPTH = 4,
   parameter AW    = 2
)
(
   // clock and reset
   input  wire             mclk,
   input  wire             rstn,
   // fill side
   input  wire             inValid,
   output wire             inReady,
   input  wire [WIDTH-1:0] inData,
   // drain side
   output wire             outValid,
   input  wire             outReady,
   output wire [WIDTH-1:0] outData
);
   reg [WIDTH-1:0] mem [0:DEPTH-1];
   reg [AW:0]      wr_reg;
   reg [AW:0]      rd_reg;

   assign inReady  = (wr_reg - rd_reg) != DEPTH[AW:0];
   assign outValid = wr_reg != rd_reg;
   assign outData  = mem[rd_reg[AW-1:0]];

   always @(posedge mclk)
   begin
      if (inValid && inReady)
         mem[wr_reg[AW-1:0]] <= inData;
   end

   always @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
      begin
         wr_reg <= {(AW+1){1'b0}};
         rd_reg <= {(AW+1){1'b0}};
      end
      else
      begin
         if (inValid && inReady)
            wr_reg <= wr_reg + 1'b1;
         if (outValid && outReady)
            rd_reg <= rd_reg + 1'b1;
      end
   end
endmodule

// ===== rtl/sadc_regs.vh
/*
 * Constants for the single-address DMA cycle sequencer: exception code
 * values, descriptor field layout, wait counts and buffer depth.
 * Assumes inclusion by bare name from the sequencer and its helpers.
 */
`ifndef SADC_REGS_VH
`define SADC_REGS_VH

// exception code values, bit 2 down to bit 0
`define SADC_BEC_NONE       3'h7
`define SADC_BEC_HALT       3'h6
`define SADC_BEC_BUSERR     3'h5
`define SADC_BEC_RETRY      3'h4
`define SADC_BEC_RELQ       3'h3
`define SADC_BEC_RESET      3'h0

// descriptor layout
`define SADC_D_ADDR_LSB     0
`define SADC_D_ADDR_MSB     23
`define SADC_D_FC_LSB       24
`define SADC_D_FC_MSB       26
`define SADC_D_WRITE        27
`define SADC_D_WORD         28
`define SADC_D_LAST         29
`define SADC_D_WIDTH        30

// wait counts, in states beyond the first one
`define SADC_PAIR_CNT       2'h1
`define SADC_TWO_WAIT_CNT   2'h3
`define SADC_FIFO_DEPTH     4
`define SADC_SYNC_WIDTH     5

`endif

// ===== rtl/sadc_sync.v
/*
 * Two-flop synchroniser with one extra stage for debounce comparison.
 * Assumes inputs asynchronous to mclk; only stages two and three feed logic.
 */
`timescale 1ns/100ps
module sadc_sync
#(
   parameter WIDTH = 5
)
(
   // clock and reset
   input  wire             mclk,
   input  wire             rstn,
   // pins and synchronised copies
   input  wire [WIDTH-1:0] pinIn,
   output reg  [WIDTH-1:0] syncOut,
   output reg  [WIDTH-1:0] syncPrev
);
   reg [WIDTH-1:0] meta_reg;

   always @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
      begin
         meta_reg <= {WIDTH{1'b1}};
         syncOut  <= {WIDTH{1'b1}};
         syncPrev <= {WIDTH{1'b1}};
      end
      else
      begin
         meta_reg <= pinIn;
         syncOut  <= meta_reg;
         syncPrev <= syncOut;
      end
   end
endmodule

// ===== verification/sadc_cycle_asserts.sv
/*
 * Checker for the DMA cycle sequencer, bound to its top module.
 * Assumes the partner holds termination until the address strobe rises.
 */
`timescale 1ns/100ps
`include "sadc_regs.vh"
module sadc_cycle_asserts (
   // clock and reset
   input wire logic       mclk,
   input wire logic       rstn,
   // configuration
   input wire logic       readyProtocol,
   input wire logic       bus8,
   input wire logic       device8,
   // bus control
   input wire logic       addrMuxOe,
   input wire logic       addrLowOe,
   input wire logic       upperAddressStrobeN,
   input wire logic       addressValidStrobeN,
   input wire logic       upperStrobeOrA0,
   input wire logic       lowerStrobeOrDsN,
   input wire logic       readWriteN,
   input wire logic       dataBufferEnableN,
   input wire logic       cycleBusy,
   // termination and handshake
   input wire logic       memoryTransferAckN,
   input wire logic [2:0] busExceptionCode,
   input wire logic       peripheralControlLineN,
   input wire logic       deviceAckN,
   input wire logic       doneN,
   input wire logic       transferCompleteStrobeN,
   input wire logic       byteLaneSwapN
);
   default clocking dc @(posedge mclk);
   endclocking
   default disable iff (!rstn);

   chk_bufen_high: assert property (
      cycleBusy |-> dataBufferEnableN) else $error("buffer enable low");
   chk_upper_two_states: assert property (
      $fell(upperAddressStrobeN) |=> !upperAddressStrobeN
      ##1 (upperAddressStrobeN && !addressValidStrobeN))
      else $error("upper strobe timing wrong");
   chk_rw_at_start: assert property (
      $fell(upperAddressStrobeN) |-> readWriteN)
      else $error("read/write low at first state");
   chk_rw_low_as: assert property (
      $fell(readWriteN) |-> $fell(addressValidStrobeN))
      else $error("write direction not with address strobe");
   chk_mux_tristate: assert property (
      $fell(addressValidStrobeN) |=> !addrMuxOe)
      else $error("address pins still driven");
   chk_ack_in_cycle: assert property (
      $fell(deviceAckN) |-> !addressValidStrobeN)
      else $error("device ack outside address phase");
   chk_cmpl_needs_ack: assert property (
      $fell(transferCompleteStrobeN) |-> !$past(memoryTransferAckN, 2)
      && $past(busExceptionCode, 2) == `SADC_BEC_NONE
      && !addressValidStrobeN) else $error("complete without ack");
   chk_cmpl_needs_rdy: assert property (
      $fell(transferCompleteStrobeN) && readyProtocol
      |-> !$past(peripheralControlLineN, 2))
      else $error("complete without ready");
   chk_release_all: assert property (
      $rose(addressValidStrobeN) |=> deviceAckN && doneN
      && transferCompleteStrobeN && byteLaneSwapN)
      else $error("handshake not negated");
   chk_strobes_off: assert property (
      $rose(addressValidStrobeN) |-> lowerStrobeOrDsN
      && (bus8 || upperStrobeOrA0)) else $error("strobes not negated");
   chk_swap_lanes: assert property (
      !byteLaneSwapN |-> device8 && !bus8 && lowerStrobeOrDsN)
      else $error("lane swap wrong");
   chk_ack_bounded: assert property (
      $fell(deviceAckN) |-> ##[1:80] deviceAckN)
      else $error("device ack stuck");
   chk_lines_idle: assert property (
      !cycleBusy |-> !addrLowOe && !addrMuxOe && addressValidStrobeN)
      else $error("bus lines driven while idle");
   chk_lines_driven: assert property (
      (!upperAddressStrobeN || !addressValidStrobeN) |-> addrLowOe)
      else $error("address lines released in cycle");
endmodule

bind sadc_cycle sadc_cycle_asserts u_sadc_cycle_asserts (
   .mclk, .rstn, .readyProtocol, .bus8, .device8, .addrMuxOe, .addrLowOe,
   .upperAddressStrobeN, .addressValidStrobeN, .upperStrobeOrA0,
   .lowerStrobeOrDsN, .readWriteN, .dataBufferEnableN, .cycleBusy,
   .memoryTransferAckN, .busExceptionCode, .peripheralControlLineN,
   .deviceAckN, .doneN, .transferCompleteStrobeN, .byteLaneSwapN);

// ===== verification/sadc_cycle_bench.sv
/*
 * Self-checking bench for the DMA cycle sequencer and its partner.
 * Assumes the partner ends every cycle by ack or exception code.
 */
`timescale 1ns/100ps
`include "sadc_regs.vh"
module sadc_cycle_bench;
   logic        mclk = 1'b0;
   logic        rstn = 1'b0;
   logic        descValid = 1'b0;
   logic [23:0] descAddr = 24'h000000;
   logic [2:0]  descFuncCode = 3'h0;
   logic        descWrite = 1'b0, descWord = 1'b0, descLast = 1'b0;
   logic        readyProtocol = 1'b0, bus8 = 1'b0, device8 = 1'b0;
   logic [2:0]  errCode = `SADC_BEC_NONE;
   logic [7:0]  ackDelay = 8'h00, rdyDelay = 8'h01;
   wire         descReady, addrMuxOe, upperAddressStrobeN, readWriteN;
   wire         addressValidStrobeN, upperStrobeOrA0, lowerStrobeOrDsN;
   wire         dataBufferEnableN, cycleBusy, memoryTransferAckN, doneN;
   wire         peripheralControlLineN, deviceAckN, byteLaneSwapN;
   wire         transferCompleteStrobeN;
   wire [23:1]  addrOut;
   wire [2:0]   function_code, busExceptionCode;
   logic [31:0] noteQ[$];
   logic [31:0] n;
   logic [2:0]  codes[4] = '{`SADC_BEC_BUSERR, `SADC_BEC_RETRY,
                             `SADC_BEC_RELQ, `SADC_BEC_RESET};
   int          bad_count = 0, compares = 0, i;
   logic        rdySamp, sawFull = 1'b0, upWas = 1'b1, avWas = 1'b1;
   logic        sCmpl, sDone, sSwap, sWr, capA0;
   logic [23:1] capAddr;
   logic [2:0]  capFc;

   sadc_cycle #(.FIFO_DEPTH(4)) u_sadc_cycle (.mclk, .rstn, .descValid,
      .descReady, .descAddr, .descFuncCode, .descWrite, .descWord,
      .descLast, .readyProtocol, .bus8, .device8, .addrOut, .addrMuxOe,
      .addrLowOe(), .function_code, .upperAddressStrobeN,
      .addressValidStrobeN, .upperStrobeOrA0, .lowerStrobeOrDsN,
      .readWriteN, .dataBufferEnableN, .cycleBusy, .memoryTransferAckN,
      .busExceptionCode, .peripheralControlLineN, .deviceAckN, .doneN,
      .transferCompleteStrobeN, .byteLaneSwapN);
   sadc_mem_model u_sadc_mem_model (.mclk, .rstn, .upperAddressStrobeN,
      .addressValidStrobeN, .deviceAckN, .errCode, .ackDelay, .rdyDelay,
      .memoryTransferAckN, .busExceptionCode, .peripheralControlLineN);

   always #5 mclk = ~mclk;
   // ready level just before each sampling edge
   always @(negedge mclk) rdySamp = descReady;

   task automatic check(input string what, input logic [23:0] seen, exp);
      compares++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task end_of_test;
      $display("mismatches %0d compares %0d", bad_count, compares);
      if (bad_count == 0 && compares > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   task automatic send(input logic [23:0] a, input logic wd);
      logic [2:0] f;
      logic       w, l;
      f = 3'($urandom);
      w = 1'($urandom);
      l = 1'($urandom);
      descAddr <= a;
      descFuncCode <= f;
      descWrite <= w;
      descWord <= wd;
      descLast <= l;
      descValid <= 1'b1;
      @(posedge mclk);
      while (rdySamp !== 1'b1)
      begin
         sawFull = 1'b1;
         @(posedge mclk);
      end
      noteQ.push_back({a, f, w, l, device8 & ~bus8 & ~a[0],
                       errCode == `SADC_BEC_NONE, bus8});
   endtask

   task automatic run(input string name, input logic [2:0] cfg,
                      input logic [2:0] ec, input int ad, pd, cnt);
      int          j, k;
      logic [23:0] a;
      logic        wd;
      {readyProtocol, bus8, device8} <= cfg;
      errCode <= ec;
      ackDelay <= 8'(ad);
      rdyDelay <= 8'(pd);
      @(posedge mclk);
      for (j = 0; j < cnt; j++)
      begin
         a = 24'($urandom);
         wd = (cfg[1] | cfg[0]) ? 1'b0 : 1'($urandom);
         if (wd)
            a[0] = 1'b0;
         send(a, wd);
      end
      descValid <= 1'b0;
      for (k = 0; k < 3000 && (noteQ.size() != 0 || cycleBusy !== 1'b0); k++)
         @(negedge mclk);
      @(posedge mclk);
      if (k == 3000)
         check("idle", 24'h1, 24'h0);
      $display("test %s done", name);
   endtask

   // one note per cycle, compared when the address strobe rises
   always @(posedge mclk)
   begin
      #1;
      if (!upperAddressStrobeN && upWas)
      begin
         capAddr = addrOut;
         capFc = function_code;
         capA0 = upperStrobeOrA0;
         {sCmpl, sDone, sSwap, sWr} = 4'h0;
      end
      sCmpl |= !transferCompleteStrobeN;
      sDone |= !doneN;
      sSwap |= !byteLaneSwapN;
      sWr |= !readWriteN;
      if (addressValidStrobeN && !avWas)
      begin
         n = (noteQ.size() != 0) ? noteQ.pop_front() : 32'h0;
         check("addr", 24'(capAddr), 24'(n[31:9]));
         check("fc", 24'(capFc), 24'(n[7:5]));
         if (n[0])
            check("a0", 24'(capA0), 24'(n[8]));
         check("cmpl", 24'(sCmpl), 24'(n[1]));
         check("done", 24'(sDone), 24'(n[3]));
         check("swap", 24'(sSwap), 24'(n[2]));
         check("rw", 24'(sWr), 24'(n[4]));
      end
      upWas = upperAddressStrobeN;
      avWas = addressValidStrobeN;
   end

   initial
   begin
      repeat (8) @(posedge mclk);
      rstn <= 1'b1;
      void'($urandom(32'hDAAF));
      @(posedge mclk);
      // back to back cycles fill the buffer
      run("ackonly", 3'h0, `SADC_BEC_NONE, 0, 1, 8);
      check("full", 24'(sawFull), 24'h1);
      run("slowmem", 3'h0, `SADC_BEC_NONE, 6, 1, 4);
      for (i = 0; i < 3; i++)
         run("ready", 3'h4, `SADC_BEC_NONE, 2, i * 3, 4);
      for (i = 0; i < 4; i++)
         run("error", 3'h0, codes[i], 1, 1, 2);
      run("dev8", 3'h1, `SADC_BEC_NONE, 1, 1, 6);
      run("bus8", 3'h7, `SADC_BEC_NONE, 0, 2, 6);
      end_of_test;
   end

   initial
   begin
      #400000;
      check("watchdog", 24'h1, 24'h0);
      end_of_test;
   end
endmodule

// ===== verification/sadc_mem_model.sv
/*
 * Memory and device partner: ends each cycle after a set delay, with
 * an exception code when asked, and answers ready to the device ack.
 * Assumes sequencer strobes change on the rising edge; pins pulled up.
 */
`timescale 1ns/100ps
`include "sadc_regs.vh"
module sadc_mem_model (
   // clock and reset
   input  wire logic       mclk,
   input  wire logic       rstn,
   // strobes watched
   input  wire logic       upperAddressStrobeN,
   input  wire logic       addressValidStrobeN,
   input  wire logic       deviceAckN,
   // behaviour, rdyDelay 0 gives early ready
   input  wire logic [2:0] errCode,
   input  wire logic [7:0] ackDelay,
   input  wire logic [7:0] rdyDelay,
   // pins driven
   output logic            memoryTransferAckN,
   output logic      [2:0] busExceptionCode,
   output logic            peripheralControlLineN
);
   logic [7:0] avCnt;
   logic [7:0] ackCnt;
   wire        term = !addressValidStrobeN && avCnt >= ackDelay;
   always @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
      begin
         avCnt <= 8'h00;
         ackCnt <= 8'h00;
         memoryTransferAckN <= 1'b1;
         busExceptionCode <= `SADC_BEC_NONE;
         peripheralControlLineN <= 1'b1;
      end
      else
      begin
         avCnt <= addressValidStrobeN ? 8'h00 : avCnt + 8'h01;
         ackCnt <= deviceAckN ? 8'h00 : ackCnt + 8'h01;
         memoryTransferAckN <= !(term && errCode == `SADC_BEC_NONE);
         busExceptionCode <= term ? errCode : `SADC_BEC_NONE;
         peripheralControlLineN <= (rdyDelay == 8'h00) ?
            (upperAddressStrobeN && addressValidStrobeN && deviceAckN) :
            (deviceAckN || ackCnt < rdyDelay);
      end
   end
endmodule
